// *** rtl/averaging_filter_readout.sv ***
// Purpose: Conversion timing, block averaging and serial readout of a
//          serial-output converter.
// Assumes: All pins are sampled by CORE_CLK; shift clock far slower.
// Notes:   Results and read-start markers pass one FIFO so that the
//          accumulator sees them in the order they happened.
`timescale 1ns/10ps

module averaging_filter_readout
(
	// Clock and reset
	input  wire logic                             CORE_CLK,
	input  wire logic                             RST_B,
	// Conversion control
	input  wire logic                             CONVERSION_TRIGGER,
	input  wire logic [avg_filter_pkg::RES_W-1:0] CORE_RESULT,
	output      logic                             BUSY,
	// Serial read port
	input  wire logic                             SCK,
	input  wire logic                             READ_SELECT_IN,
	input  wire logic                             CASCADE_SEL,
	output      logic                             SERIAL_OUT,
	output      logic                             SERIAL_OUT_OE
);

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisation and edge detection

	logic [avg_filter_pkg::PIN_N-1:0] pin_raw;
	logic [avg_filter_pkg::PIN_N-1:0] pin_s;
	logic [avg_filter_pkg::PIN_N-1:0] pin_d_r;
	logic                             trig_rise;
	logic                             sck_rise;
	logic                             sck_fall;
	logic                             sck_enable;
	logic                             sck_take;
	logic                             sck_shift;

	assign pin_raw = {CASCADE_SEL, READ_SELECT_IN, SCK, CONVERSION_TRIGGER};

	pin_sync
	#(
		.W (avg_filter_pkg::PIN_N)
	)
	u_pin_sync
	(
		.clk   (CORE_CLK),
		.rst_b (RST_B),
		.d     (pin_raw),
		.q     (pin_s)
	);

	always_ff @(posedge CORE_CLK)
	begin
		if (!RST_B)
			pin_d_r <= '0;
		else
			pin_d_r <= pin_s;
	end

	assign trig_rise  = pin_s[avg_filter_pkg::PIN_TRIG] &
	                    ~pin_d_r[avg_filter_pkg::PIN_TRIG];
	assign sck_rise   = pin_s[avg_filter_pkg::PIN_SCK] &
	                    ~pin_d_r[avg_filter_pkg::PIN_SCK];
	assign sck_fall   = ~pin_s[avg_filter_pkg::PIN_SCK] &
	                    pin_d_r[avg_filter_pkg::PIN_SCK];
	// Normal mode only: read select low enables the port
	assign sck_enable = ~pin_s[avg_filter_pkg::PIN_RSEL] &
	                    ~pin_s[avg_filter_pkg::PIN_CASC];
	assign sck_take   = sck_rise & sck_enable;
	assign sck_shift  = sck_fall & sck_enable;

	////////////////////////////////////////////////////////////////////////
	// Conversion timing

	avg_filter_pkg::conv_state_t                state_r;
	avg_filter_pkg::conv_state_t                state_nxt;
	logic [avg_filter_pkg::CONV_W-1:0]          conv_cnt_r;
	logic [avg_filter_pkg::CONV_W-1:0]          conv_cnt_nxt;
	logic [avg_filter_pkg::RES_W-1:0]           result_r;
	logic                                       conv_end;
	logic                                       busy_fall;
	logic                                       fifo_in_ready;

	always_comb
	begin
		state_nxt    = state_r;
		conv_cnt_nxt = conv_cnt_r;
		unique case (state_r)
			avg_filter_pkg::ST_IDLE:
			begin
				// A full FIFO holds off new conversions
				if (trig_rise && fifo_in_ready)
				begin
					state_nxt    = avg_filter_pkg::ST_CONV;
					conv_cnt_nxt = avg_filter_pkg::CONV_LAST;
				end
			end
			avg_filter_pkg::ST_CONV:
			begin
				if (conv_cnt_r == '0)
					state_nxt = avg_filter_pkg::ST_DONE;
				else
					conv_cnt_nxt = conv_cnt_r - 1'b1;
			end
			avg_filter_pkg::ST_DONE:
			begin
				if (fifo_in_ready)
					state_nxt = avg_filter_pkg::ST_IDLE;
			end
			default:
			begin
				state_nxt = avg_filter_pkg::ST_IDLE;
			end
		endcase
	end

	assign conv_end  = (state_r == avg_filter_pkg::ST_CONV) &&
	                   (conv_cnt_r == '0);
	assign busy_fall = (state_r == avg_filter_pkg::ST_DONE) & fifo_in_ready;
	// Triggers seen outside idle are dropped
	assign BUSY      = (state_r != avg_filter_pkg::ST_IDLE);

	always_ff @(posedge CORE_CLK)
	begin
		if (!RST_B)
		begin
			state_r    <= avg_filter_pkg::ST_IDLE;
			conv_cnt_r <= '0;
			result_r   <= '0;
		end
		else
		begin
			state_r    <= state_nxt;
			conv_cnt_r <= conv_cnt_nxt;
			if (conv_end)
				result_r <= CORE_RESULT;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read tracking per conversion cycle

	logic [avg_filter_pkg::SCNT_W-1:0] sck_cnt_r;
	logic [avg_filter_pkg::SCNT_W-1:0] cyc_cnt;
	logic                              load_ok;
	logic                              read_active_r;
	logic                              read_start;
	logic                              clear_pend_r;
	logic                              push_conv;
	logic                              push_clear;
	logic                              fifo_in_valid;
	logic [avg_filter_pkg::FIFO_W-1:0] fifo_in_data;

	assign cyc_cnt    = (sck_take &&
	                     sck_cnt_r != avg_filter_pkg::SCK_CNT_MAX) ?
	                    sck_cnt_r + 1'b1 : sck_cnt_r;
	// Zero or at least twenty edges release the shift register
	assign load_ok    = (cyc_cnt == '0) ||
	                    (cyc_cnt >= avg_filter_pkg::SCK_TERM_CNT);
	assign read_start = sck_take & ~read_active_r;
	assign push_conv  = busy_fall;
	// Marker goes behind any result completed before the read began
	assign push_clear = clear_pend_r & ~push_conv & fifo_in_ready;
	assign fifo_in_valid = push_conv | push_clear;
	assign fifo_in_data  = push_conv ?
	                       {1'b0, load_ok, result_r} :
	                       {1'b1, 1'b0, {avg_filter_pkg::RES_W{1'b0}}};

	always_ff @(posedge CORE_CLK)
	begin
		if (!RST_B)
		begin
			sck_cnt_r     <= '0;
			read_active_r <= 1'b0;
			clear_pend_r  <= 1'b0;
		end
		else
		begin
			sck_cnt_r     <= busy_fall ? '0 : cyc_cnt;
			read_active_r <= read_start |
			                 (read_active_r & ~(busy_fall & load_ok));
			clear_pend_r  <= read_start | (clear_pend_r & ~push_clear);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Result FIFO

	logic                              fifo_out_valid;
	logic                              fifo_out_ready;
	logic [avg_filter_pkg::FIFO_W-1:0] fifo_out_data;

	stream_fifo
	#(
		.W     (avg_filter_pkg::FIFO_W),
		.DEPTH (avg_filter_pkg::FIFO_DEPTH)
	)
	u_fifo
	(
		.clk       (CORE_CLK),
		.rst_b     (RST_B),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (fifo_in_data),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (fifo_out_data)
	);

	////////////////////////////////////////////////////////////////////////
	// Accumulator

	logic signed [avg_filter_pkg::ACC_W-1:0] acc_r;
	logic signed [avg_filter_pkg::ACC_W-1:0] sample_ext;
	logic [avg_filter_pkg::NUM_W-1:0]        num_r;
	logic [avg_filter_pkg::NUM_W-1:0]        num_inc;
	logic                                    load_pend_r;
	logic                                    drain;
	logic                                    d_clear;
	logic                                    d_load;

	// Drain stalls for one cycle while the shift register loads
	assign fifo_out_ready = ~load_pend_r;
	assign drain      = fifo_out_valid & fifo_out_ready;
	assign d_clear    = fifo_out_data[avg_filter_pkg::TAG_CLEAR];
	assign d_load     = fifo_out_data[avg_filter_pkg::TAG_LOAD];
	assign sample_ext = {{(avg_filter_pkg::ACC_W - avg_filter_pkg::RES_W)
	                     {fifo_out_data[avg_filter_pkg::RES_W-1]}},
	                     fifo_out_data[avg_filter_pkg::RES_W-1:0]};
	assign num_inc    = (num_r == avg_filter_pkg::NUM_MAX) ?
	                    num_r : num_r + 1'b1;

	always_ff @(posedge CORE_CLK)
	begin
		if (!RST_B)
		begin
			acc_r       <= '0;
			num_r       <= '0;
			load_pend_r <= 1'b0;
		end
		else
		begin
			load_pend_r <= drain & ~d_clear & d_load;
			if (drain && d_clear)
			begin
				acc_r <= '0;
				num_r <= '0;
			end
			else if (drain)
			begin
				acc_r <= acc_r + sample_ext;
				num_r <= num_inc;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Weighting, clamp and tally

	function automatic logic [avg_filter_pkg::SHIFT_W-1:0] div_shift
	(
		input logic [avg_filter_pkg::NUM_W-1:0] n
	);
		logic [avg_filter_pkg::SHIFT_W-1:0] k;
		k = '0;
		for (int i = 0; i < avg_filter_pkg::DIV_SHIFT_MAX; i++)
			if (n > (avg_filter_pkg::NUM_W'(1) << i))
				k = avg_filter_pkg::SHIFT_W'(i + 1);
		return k;
	endfunction : div_shift

	logic [avg_filter_pkg::SHIFT_W-1:0]      shift_k;
	logic signed [avg_filter_pkg::ACC_W-1:0] avg_full;
	logic                                    pos_over;
	logic                                    neg_over;
	logic [avg_filter_pkg::RES_W-1:0]        avg_code;
	logic [avg_filter_pkg::NUM_W-1:0]        num_m1;
	logic [avg_filter_pkg::TALLY_W-1:0]      tally;

	assign shift_k  = div_shift(num_r);
	assign avg_full = acc_r >>> shift_k;
	assign pos_over = (avg_full > avg_filter_pkg::POS_FS);
	assign neg_over = (avg_full < avg_filter_pkg::NEG_FS);
	// Clamp only at full scale, never at the reduced N/M level
	assign avg_code = pos_over ?
	                  avg_filter_pkg::POS_FS[avg_filter_pkg::RES_W-1:0] :
	                  neg_over ?
	                  avg_filter_pkg::NEG_FS[avg_filter_pkg::RES_W-1:0] :
	                  avg_full[avg_filter_pkg::RES_W-1:0];
	assign num_m1   = num_r - 1'b1;
	assign tally    = (num_r == '0) ? '0 :
	                  (num_m1 > avg_filter_pkg::TALLY_SAT) ?
	                  avg_filter_pkg::TALLY_SAT[avg_filter_pkg::TALLY_W-1:0] :
	                  num_m1[avg_filter_pkg::TALLY_W-1:0];

	////////////////////////////////////////////////////////////////////////
	// Output shift register

	logic [avg_filter_pkg::WORD_W-1:0] shift_r;
	logic [avg_filter_pkg::WORD_W-1:0] shift_nxt;

	assign shift_nxt = load_pend_r ? {avg_code, tally} :
	                   sck_shift ?
	                   {shift_r[avg_filter_pkg::WORD_W-2:0], 1'b0} :
	                   shift_r;

	always_ff @(posedge CORE_CLK)
	begin
		if (!RST_B)
			shift_r <= '0;
		else
			shift_r <= shift_nxt;
	end

	assign SERIAL_OUT    = shift_r[avg_filter_pkg::WORD_W-1];
	assign SERIAL_OUT_OE = sck_enable;

endmodule : averaging_filter_readout

// *** rtl/avg_filter_pkg.sv ***
// Purpose: Shared constants and types for the averaging filter readout.
// Assumes: Core clock of 20 MHz; 24-bit signed conversion results.
// Notes:   Conversion time rounds down to whole core clock cycles.
package avg_filter_pkg;

	// Data widths
	localparam int RES_W   = 24;
	localparam int TALLY_W = 16;
	localparam int WORD_W  = RES_W + TALLY_W;
	localparam int ACC_W   = 48;
	localparam int NUM_W   = 17;
	localparam int SCNT_W  = 5;
	localparam int SHIFT_W = 5;

	// Averaging limits
	localparam int                      DIV_SHIFT_MAX = 16;
	localparam logic [NUM_W-1:0]        NUM_MAX       = 17'h1ffff;
	localparam logic [NUM_W-1:0]        TALLY_SAT     = 17'h0ffff;
	localparam logic signed [ACC_W-1:0] POS_FS        = 48'sh0000007fffff;
	localparam logic signed [ACC_W-1:0] NEG_FS        = 48'shffffff800000;

	// Shift clock edges per cycle that end a read
	localparam logic [SCNT_W-1:0] SCK_TERM_CNT = 5'h14;
	localparam logic [SCNT_W-1:0] SCK_CNT_MAX  = 5'h1f;

	// Conversion timing
	localparam int               CLK_PERIOD_NS = 50;
	localparam int               CONV_TIME_NS  = 392;
	localparam int               CONV_CYCLES   = CONV_TIME_NS / CLK_PERIOD_NS;
	localparam int               CONV_W        = 4;
	// Busy spans the counted cycles plus the hand-off cycle
	localparam logic [CONV_W-1:0] CONV_LAST    = CONV_W'(CONV_CYCLES - 2);

	// Result FIFO word: {clear marker, load request, result}
	localparam int FIFO_DEPTH = 8;
	localparam int TAG_LOAD   = RES_W;
	localparam int TAG_CLEAR  = RES_W + 1;
	localparam int FIFO_W     = RES_W + 2;

	// Synchronised pin positions
	localparam int PIN_TRIG = 0;
	localparam int PIN_SCK  = 1;
	localparam int PIN_RSEL = 2;
	localparam int PIN_CASC = 3;
	localparam int PIN_N    = 4;

	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b00,
		ST_CONV = 2'b01,
		ST_DONE = 2'b11
	} conv_state_t;

endpackage : avg_filter_pkg

// *** rtl/pin_sync.sv ***
// Purpose: Two flip-flop synchroniser for a group of pin inputs.
// Assumes: Each bit is an independent level.
// Notes:   Only the second stage is visible outside.
`timescale 1ns/10ps
module pin_sync
#(
	parameter int W = 4
)
(
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_b,
	// Pins
	input  wire logic [W-1:0] d,
	output      logic [W-1:0] q
);

	logic [W-1:0] meta_r;

	genvar gi;
	generate
		for (gi = 0; gi < W; gi++)
		begin : g_bit
			always_ff @(posedge clk)
			begin
				if (!rst_b)
				begin
					meta_r[gi] <= 1'b0;
					q[gi]      <= 1'b0;
				end
				else
				begin
					meta_r[gi] <= d[gi];
					q[gi]      <= meta_r[gi];
				end
			end
		end
	endgenerate

endmodule : pin_sync

// *** rtl/stream_fifo.sv ***
// Purpose: Small synchronous FIFO with valid/ready on both sides.
// Assumes: DEPTH is a power of two.
// Notes:   First word falls through; storage is not reset.
`timescale 1ns/10ps
module stream_fifo
#(
	parameter int W     = 26,
	parameter int DEPTH = 8
)
(
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_b,
	// Fill side
	input  wire logic         in_valid,
	output      logic         in_ready,
	input  wire logic [W-1:0] in_data,
	// Drain side
	output      logic         out_valid,
	input  wire logic         out_ready,
	output      logic [W-1:0] out_data
);

	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem_r [DEPTH];
	logic [AW:0]  wr_r;
	logic [AW:0]  rd_r;
	logic         full;
	logic         push;
	logic         pop;

	assign full      = (wr_r[AW] != rd_r[AW]) &&
	                   (wr_r[AW-1:0] == rd_r[AW-1:0]);
	assign in_ready  = ~full;
	assign out_valid = (wr_r != rd_r);
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign out_data  = mem_r[rd_r[AW-1:0]];

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			wr_r <= '0;
			rd_r <= '0;
		end
		else
		begin
			if (push)
				wr_r <= wr_r + 1'b1;
			if (pop)
				rd_r <= rd_r + 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (push)
			mem_r[wr_r[AW-1:0]] <= in_data;
	end

endmodule : stream_fifo

// *** verification/averaging_filter_readout_asserts.sv ***
// Purpose: Pin-level timing checks for the averaging filter readout.
// Assumes: Result FIFO never fills; no load while the host holds SCK high.
// Notes:   Bound to every instance of the block.
`timescale 1ns/10ps
module averaging_filter_readout_asserts
(
	// Clock and reset
	input wire logic                             CORE_CLK,
	input wire logic                             RST_B,
	// Conversion
	input wire logic                             CONVERSION_TRIGGER,
	input wire logic [avg_filter_pkg::RES_W-1:0] CORE_RESULT,
	input wire logic                             BUSY,
	// Serial port
	input wire logic                             SCK,
	input wire logic                             READ_SELECT_IN,
	input wire logic                             CASCADE_SEL,
	input wire logic                             SERIAL_OUT,
	input wire logic                             SERIAL_OUT_OE
);
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!RST_B);

	////////////////////////////////////////////////////////////////////////
	busy_len_a: assert property ($rose(BUSY) |-> BUSY[*7])
		else $error("busy shorter than a conversion");
	busy_end_a: assert property ($rose(BUSY) |-> ##7 !BUSY)
		else $error("busy did not fall in time");
	busy_cause_a: assert property
		($rose(BUSY) |-> $past(CONVERSION_TRIGGER, 2))
		else $error("busy rose without a trigger");
	busy_quiet_a: assert property
		((!CONVERSION_TRIGGER)[*6] |=> !$rose(BUSY))
		else $error("busy rose with trigger idle");
	oe_rsel_a: assert property
		(READ_SELECT_IN[*4] |-> !SERIAL_OUT_OE)
		else $error("output driven while deselected");
	oe_on_a: assert property
		((!READ_SELECT_IN && !CASCADE_SEL)[*5] |-> SERIAL_OUT_OE)
		else $error("output not driven while selected");
	casc_off_a: assert property
		(CASCADE_SEL[*4] |-> !SERIAL_OUT_OE)
		else $error("output driven in chain mode");
	sdo_hold_a: assert property
		((SCK && $past(SCK, 1) && $past(SCK, 2) && $past(SCK, 3)) |->
		 $stable(SERIAL_OUT))
		else $error("data moved while shift clock high");

	cover property ($fell(BUSY));
	cover property (BUSY && $rose(CONVERSION_TRIGGER));
	cover property ($rose(SERIAL_OUT_OE));
endmodule : averaging_filter_readout_asserts

bind averaging_filter_readout averaging_filter_readout_asserts chk_u
(
	.CORE_CLK           (CORE_CLK),
	.RST_B              (RST_B),
	.CONVERSION_TRIGGER (CONVERSION_TRIGGER),
	.CORE_RESULT        (CORE_RESULT),
	.BUSY               (BUSY),
	.SCK                (SCK),
	.READ_SELECT_IN     (READ_SELECT_IN),
	.CASCADE_SEL        (CASCADE_SEL),
	.SERIAL_OUT         (SERIAL_OUT),
	.SERIAL_OUT_OE      (SERIAL_OUT_OE)
);

// *** verification/host_model.sv ***
// Purpose: Host side of the serial link: shift clock and bit capture.
// Assumes: Called from the bench at a core clock edge.
// Notes:   Shift clock idles low between pulses, period 400 ns.
`timescale 1ns/10ps
module host_model
(
	// Clock
	input  wire logic clk,
	// Serial link
	output      logic sck = 1'b0,
	input  wire logic serial_out,
	input  wire logic sdo_oe
);
	logic last_r = 1'b0;
	wire  logic line = sdo_oe ? serial_out : ~last_r;

	////////////////////////////////////////////////////////////////////////
	// One pulse, bit taken at the rising edge; the bench decides how many pulses
	// a read gets and may spread one read over several conversion cycles
	task automatic pulse(output logic b);
		@(posedge clk);
		sck <= 1'b1;
		b = line;
		last_r = line;
		repeat (4) @(posedge clk);
		sck <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : pulse
endmodule : host_model

// *** verification/test_averaging_filter_readout.sv ***
// Purpose: Self-checking bench for the averaging filter readout.
// Assumes: Reference model tracks sum, count and read state.
// Notes:   Tally saturation needs 65537 conversions and is left out.
`timescale 1ns/10ps
module test_averaging_filter_readout;
	logic                             core_clk    = 1'b0;
	logic                             rst_b       = 1'b0;
	logic                             trig        = 1'b0;
	logic [avg_filter_pkg::RES_W-1:0] result      = 24'h000000;
	logic                             rsel        = 1'b0;
	logic                             casc        = 1'b0;
	wire  logic                       busy;
	wire  logic                       serial_out;
	wire  logic                       sdo_oe;
	wire  logic                       sck;
	int                               err_count   = 0;
	int                               checks_done = 0;
	longint                           sum         = 0;
	int                               n           = 0;
	int                               cnt         = 0;
	int                               pos         = 0;
	bit                               act         = 1'b0;
	logic [39:0]                      word_e      = 40'h0;

	always #25 core_clk = ~core_clk;

	averaging_filter_readout dut_u
	(
		.CORE_CLK           (core_clk),
		.RST_B              (rst_b),
		.CONVERSION_TRIGGER (trig),
		.CORE_RESULT        (result),
		.BUSY               (busy),
		.SCK                (sck),
		.READ_SELECT_IN     (rsel),
		.CASCADE_SEL        (casc),
		.SERIAL_OUT         (serial_out),
		.SERIAL_OUT_OE      (sdo_oe)
	);

	host_model host_u
	(
		.clk    (core_clk),
		.sck    (sck),
		.serial_out    (serial_out),
		.sdo_oe (sdo_oe)
	);

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	function automatic logic [39:0] avg_word();
		int          k;
		longint      q;
		logic [15:0] t;
		k = 0;
		while ((1 << k) < n && k < 16)
			k++;
		q = sum >>> k;
		if (q > 64'sh7fffff)
			q = 64'sh7fffff;
		if (q < -64'sh800000)
			q = -64'sh800000;
		t = (n == 0) ? 16'h0000 : ((n > 65536) ? 16'hffff : 16'(n - 1));
		return {q[23:0], t};
	endfunction : avg_word

	task automatic rd(input int bits);
		logic b;
		logic exp_bit;
		for (int i = 0; i < bits; i++)
		begin
			host_u.pulse(b);
			if (!rsel)
			begin
				if (!act)
				begin
					act = 1'b1;
					sum = 0;
					n = 0;
				end
				cnt++;
				exp_bit = (pos < 40) ? word_e[39 - pos] : 1'b0;
				chk({39'h0, b}, {39'h0, exp_bit});
				pos++;
			end
		end
	endtask : rd

	task automatic conv(input logic [23:0] r, input bit again);
		int w;
		int hi;
		bit ok_len;
		@(posedge core_clk);
		result <= r;
		trig   <= 1'b1;
		w  = 0;
		hi = 0;
		// Count the cycles busy stands; a retrigger lands while it is high
		while ((hi == 0 || busy !== 1'b0) && w < 40)
		begin
			@(posedge core_clk);
			w++;
			if (busy === 1'b1)
				hi++;
			if (w == 6 || (again && w == 9))
				trig <= 1'b0;
			if (again && w == 7)
				trig <= 1'b1;
			if (again && w == 9)
				chk({39'h0, busy}, 40'h1);
		end
		ok_len = (hi > 0) && (hi <= avg_filter_pkg::CONV_CYCLES);
		chk({39'h0, ok_len}, 40'h1);
		sum += longint'($signed(r));
		n++;
		if (cnt == 0 || cnt >= 20)
		begin
			act = 1'b0;
			word_e = avg_word();
			pos = 0;
		end
		cnt = 0;
		repeat (10) @(posedge core_clk);
		chk({39'h0, busy}, 40'h0);
	endtask : conv

	////////////////////////////////////////////////////////////////////////
	task automatic s_conventional();
		conv(24'h123456, 1'b0);
		rd(40);
		conv(24'hfedcba, 1'b1);
		rd(40);
	endtask : s_conventional

	task automatic s_avg3();
		repeat (3) conv(24'h400000, 1'b0);
		rd(40);
	endtask : s_avg3

	task automatic s_distributed();
		rd(19);
		conv(24'h800010, 1'b0);
		rd(1);
		conv(24'hc00000, 1'b0);
		rd(20);
		conv(24'hff0000, 1'b0);
		rd(40);
	endtask : s_distributed

	task automatic s_rsel();
		@(posedge core_clk);
		rsel <= 1'b1;
		repeat (4) @(posedge core_clk);
		chk({39'h0, sdo_oe}, 40'h0);
		rd(5);
		conv(24'h0a0a0a, 1'b0);
		@(posedge core_clk);
		rsel <= 1'b0;
		casc <= 1'b1;
		repeat (5) @(posedge core_clk);
		chk({39'h0, sdo_oe}, 40'h0);
		casc <= 1'b0;
		repeat (5) @(posedge core_clk);
		chk({39'h0, sdo_oe}, 40'h1);
		rd(40);
	endtask : s_rsel

	task automatic print_verdict();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : print_verdict

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		#1_000_000;
		err_count++;
		print_verdict();
	end

	initial
	begin
		repeat (6) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (5) @(posedge core_clk);
		chk({39'h0, sdo_oe}, 40'h1);
		s_conventional();
		s_avg3();
		s_distributed();
		s_rsel();
		print_verdict();
	end
endmodule : test_averaging_filter_readout
